// ===== rtl/amplitude_ramp_and_update_control.sv
// Purpose: Amplitude keying ramp, profile select capture and update strobe generation
// Assumes: All pins synchronous to core_clk; strobe pin split into in, out, enable
// Notes: Internal update period counts quarter-clock ticks divided by rate code
`timescale 1ns/1ns
`default_nettype none
module amplitude_ramp_and_update_control (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register write and read port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [4:0] regAddr,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata,
    // Mode and control pins
    input wire logic singleToneMode,
    input wire logic amplitudeKeying,
    input wire logic profile_select_bit2,
    input wire logic profile_select_bit1,
    input wire logic profile_select_bit0,
    // Update strobe pin
    input wire logic updatePinIn,
    output logic updatePinOut,
    output logic updatePinOe_n,
    // Results
    output logic [13:0] ampScale,
    output logic [13:0] rampAmp,
    output logic [2:0] activeProfile,
    output logic keyClockRun
);
    logic [ramp_pkg::CTRL_WIDTH-1:0] ctrlBuf_reg, ctrlBuf_next, ctrlAct_reg, ctrlAct_next;
    logic [31:0] rampBuf_reg, rampBuf_next, rampAct_reg, rampAct_next;
    logic [31:0] rateBuf_reg, rateBuf_next, rateAct_reg, rateAct_next;
    logic [2:0] profile_reg, profile_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [2:0] profilePins;
    logic profChange, keyChange, extRise, updateEvt, intUpdate;
    logic keyEn, autoSel, manExt, reloadOnStrobe, intUpdEn, autoActive;
    logic [1:0] rateCode;
    logic [15:0] interval;
    logic [13:0] maxAmp;
    logic [4:0] stepInc;

    assign profilePins = {profile_select_bit2, profile_select_bit1, profile_select_bit0};

    edge_sense #(.WIDTH(3)) profileSense (
        .core_clk(core_clk),
        .rst(rst),
        .level(profilePins),
        .prevLevel(),
        .changed(profChange),
        .rose()
    );

    edge_sense #(.WIDTH(1)) keySense (
        .core_clk(core_clk),
        .rst(rst),
        .level(amplitudeKeying),
        .prevLevel(),
        .changed(keyChange),
        .rose()
    );

    edge_sense #(.WIDTH(1)) strobeSense (
        .core_clk(core_clk),
        .rst(rst),
        .level(updatePinIn),
        .prevLevel(),
        .changed(),
        .rose(extRise)
    );

    // Pin input only counts while nobody inside drives it
    assign updateEvt = (extRise && !intUpdEn) || intUpdate || profChange;

    assign keyEn = ctrlAct_reg[ramp_pkg::KEY_EN_BIT];
    assign autoSel = ctrlAct_reg[ramp_pkg::AUTO_SEL_BIT];
    assign manExt = ctrlAct_reg[ramp_pkg::MAN_EXT_BIT];
    assign reloadOnStrobe = ctrlAct_reg[ramp_pkg::RELOAD_BIT];
    assign intUpdEn = ctrlAct_reg[ramp_pkg::INT_UPD_BIT];
    assign rateCode = ctrlAct_reg[ramp_pkg::RATE_CODE_LSB +: 2];
    assign interval = rampAct_reg[ramp_pkg::INTERVAL_LSB +: 16];
    assign maxAmp = rampAct_reg[ramp_pkg::MAX_LSB +: 14];
    assign stepInc = 5'h01 << rampAct_reg[ramp_pkg::STEP_LSB +: 2];
    assign autoActive = singleToneMode && keyEn && autoSel;

    // Register file: buffered copies, active copies, read data
    always_comb begin
        ctrlBuf_next = ctrlBuf_reg;
        rampBuf_next = rampBuf_reg;
        rateBuf_next = rateBuf_reg;
        rdata_next = rdata_reg;
        if (regWrite) begin
            unique case (regAddr)
                ramp_pkg::CTRL_ADDR: ctrlBuf_next = regWdata[ramp_pkg::CTRL_WIDTH-1:0];
                ramp_pkg::RAMP_ADDR: rampBuf_next = regWdata;
                ramp_pkg::RATE_ADDR: rateBuf_next = regWdata;
                default: ;
            endcase
        end
        if (regRead) begin
            unique case (regAddr)
                ramp_pkg::CTRL_ADDR: rdata_next = {25'h0000000, ctrlBuf_reg};
                ramp_pkg::RAMP_ADDR: rdata_next = rampBuf_reg;
                ramp_pkg::RATE_ADDR: rdata_next = rateBuf_reg;
                ramp_pkg::STATUS_ADDR: rdata_next = {13'h0000, profile_reg, 2'h0, rampAmp};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        // Writes land in buffers only; active copies move on update
        ctrlAct_next = updateEvt ? ctrlBuf_reg : ctrlAct_reg;
        rampAct_next = updateEvt ? rampBuf_reg : rampAct_reg;
        rateAct_next = updateEvt ? rateBuf_reg : rateAct_reg;
        profile_next = profChange ? profilePins : profile_reg;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrlBuf_reg <= ramp_pkg::CTRL_RESET;
            ctrlAct_reg <= ramp_pkg::CTRL_RESET;
            rampBuf_reg <= ramp_pkg::RAMP_RESET;
            rampAct_reg <= ramp_pkg::RAMP_RESET;
            rateBuf_reg <= ramp_pkg::RATE_RESET;
            rateAct_reg <= ramp_pkg::RATE_RESET;
            profile_reg <= 3'h0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ctrlBuf_reg <= ctrlBuf_next;
            ctrlAct_reg <= ctrlAct_next;
            rampBuf_reg <= rampBuf_next;
            rampAct_reg <= rampAct_next;
            rateBuf_reg <= rateBuf_next;
            rateAct_reg <= rateAct_next;
            profile_reg <= profile_next;
            rdata_reg <= rdata_next;
        end
    end

    assign regRdata = rdata_reg;
    assign activeProfile = profile_reg;

    // Keying: quarter-rate tick, step timer, ramp amplitude
    logic [1:0] keyPre_reg, keyPre_next;
    logic [15:0] stepTimer_reg, stepTimer_next;
    logic [13:0] ramp_reg, ramp_next, scale_reg, scale_next;
    logic keyTick, stepEvt, reloadEvt, autoSelRise;
    logic [14:0] upSum;

    // Prescaler held in reset when keying is off, so its clocks stop
    assign keyClockRun = singleToneMode && keyEn;
    assign keyTick = keyClockRun && (keyPre_reg == 2'(ramp_pkg::QUARTER_DIV - 1));
    assign stepEvt = keyTick && (stepTimer_reg <= 16'h0001);
    assign autoSelRise = updateEvt && ctrlBuf_reg[ramp_pkg::AUTO_SEL_BIT] && !autoSel;
    assign reloadEvt = autoSelRise || keyChange || (reloadOnStrobe && updateEvt);
    assign upSum = {1'b0, ramp_reg} + {10'h000, stepInc};

    always_comb begin
        keyPre_next = keyClockRun ? keyPre_reg + 2'h1 : 2'h0;
        stepTimer_next = stepTimer_reg;
        if (!keyClockRun) begin
            stepTimer_next = interval;
        end else if (reloadEvt) begin
            stepTimer_next = interval;
        end else if (keyTick) begin
            stepTimer_next = stepEvt ? interval : stepTimer_reg - 16'h0001;
        end
        ramp_next = ramp_reg;
        if (!autoActive) begin
            ramp_next = 14'h0000;
        end else if (ramp_reg > maxAmp) begin
            // Maximum lowered by an update: pull down first, so a down step cannot stay above it
            ramp_next = maxAmp;
        end else if (stepEvt) begin
            if (amplitudeKeying) begin
                ramp_next = (upSum > {1'b0, maxAmp}) ? maxAmp : upSum[13:0];
            end else begin
                ramp_next = (ramp_reg > {9'h000, stepInc}) ? ramp_reg - {9'h000, stepInc} : 14'h0000;
            end
        end
        if (!keyClockRun) begin
            scale_next = ramp_pkg::FULL_SCALE;
        end else if (autoSel) begin
            scale_next = ramp_next;
        end else if (manExt && !amplitudeKeying) begin
            scale_next = 14'h0000;
        end else begin
            scale_next = maxAmp;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            keyPre_reg <= 2'h0;
            stepTimer_reg <= 16'h0000;
            ramp_reg <= 14'h0000;
            scale_reg <= ramp_pkg::FULL_SCALE;
        end else begin
            keyPre_reg <= keyPre_next;
            stepTimer_reg <= stepTimer_next;
            ramp_reg <= ramp_next;
            scale_reg <= scale_next;
        end
    end

    assign rampAmp = ramp_reg;
    assign ampScale = scale_reg;

    // Internal update generator
    logic [1:0] updPre_reg, updPre_next;
    logic [2:0] div_reg, div_next;
    logic [31:0] updCnt_reg, updCnt_next;
    logic [3:0] pulse_reg, pulse_next;
    logic pinOut_reg, pinOut_next;
    logic quarterTick, divTick, staticHigh;
    logic [2:0] divMask;
    logic [31:0] period;

    assign quarterTick = intUpdEn && (updPre_reg == 2'(ramp_pkg::QUARTER_DIV - 1));
    assign divMask = 3'((4'h1 << rateCode) - 4'h1);
    assign divTick = quarterTick && ((div_reg & divMask) == divMask);
    // Quarter clock ticks absorb the factor four of the rate word
    assign period = rateAct_reg >> 2;
    assign staticHigh = rateAct_reg <= ramp_pkg::STATIC_RATE_MAX;
    assign intUpdate = intUpdEn && !staticHigh && divTick && (updCnt_reg >= period - 32'h1);

    always_comb begin
        updPre_next = intUpdEn ? updPre_reg + 2'h1 : 2'h0;
        div_next = !intUpdEn ? 3'h0 : (quarterTick ? div_reg + 3'h1 : div_reg);
        updCnt_next = updCnt_reg;
        if (!intUpdEn || intUpdate) begin
            updCnt_next = 32'h0000_0000;
        end else if (divTick) begin
            updCnt_next = updCnt_reg + 32'h1;
        end
        pulse_next = 4'h0;
        if (intUpdate) begin
            pulse_next = ramp_pkg::STROBE_PULSE_CYCLES;
        end else if (pulse_reg != 4'h0) begin
            pulse_next = pulse_reg - 4'h1;
        end
        pinOut_next = intUpdEn && (staticHigh || pulse_next != 4'h0);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            updPre_reg <= 2'h0;
            div_reg <= 3'h0;
            updCnt_reg <= 32'h0000_0000;
            pulse_reg <= 4'h0;
            pinOut_reg <= 1'b0;
        end else begin
            updPre_reg <= updPre_next;
            div_reg <= div_next;
            updCnt_reg <= updCnt_next;
            pulse_reg <= pulse_next;
            pinOut_reg <= pinOut_next;
        end
    end

    assign updatePinOut = pinOut_reg;
    assign updatePinOe_n = !intUpdEn;

    // Checks
    sequence s_pulseHigh;
        updatePinOut [*8] ##1 updatePinOut [*4];
    endsequence

    property p_zeroWhenOff;
        @(posedge core_clk) disable iff (rst) !autoActive |=> rampAmp == 14'h0000;
    endproperty
    a_zeroWhenOff: assert property (p_zeroWhenOff) else $error("ramp not zero outside auto mode");

    property p_clamp;
        @(posedge core_clk) disable iff (rst) autoActive && !updateEvt |=> rampAmp <= $past(maxAmp);
    endproperty
    a_clamp: assert property (p_clamp) else $error("ramp above maximum");

    property p_stepUp;
        @(posedge core_clk) disable iff (rst)
            autoActive && stepEvt && amplitudeKeying && upSum <= {1'b0, maxAmp}
            |=> rampAmp == $past(ramp_reg) + 14'($past(stepInc));
    endproperty
    a_stepUp: assert property (p_stepUp) else $error("wrong upward step");

    property p_stepDown;
        @(posedge core_clk) disable iff (rst)
            autoActive && stepEvt && !amplitudeKeying |=> rampAmp < $past(ramp_reg) || rampAmp == 14'h0000;
    endproperty
    a_stepDown: assert property (p_stepDown) else $error("ramp did not fall");

    property p_reloadOnKey;
        @(posedge core_clk) disable iff (rst) keyClockRun && keyChange |=> stepTimer_reg == $past(interval);
    endproperty
    a_reloadOnKey: assert property (p_reloadOnKey) else $error("timer not reloaded on pin change");

    property p_reloadOnUpdate;
        @(posedge core_clk) disable iff (rst)
            keyClockRun && reloadOnStrobe && updateEvt |=> stepTimer_reg == $past(interval);
    endproperty
    a_reloadOnUpdate: assert property (p_reloadOnUpdate) else $error("timer not reloaded on update");

    property p_transfer;
        @(posedge core_clk) disable iff (rst)
            updateEvt |=> rampAct_reg == $past(rampBuf_reg) && rateAct_reg == $past(rateBuf_reg);
    endproperty
    a_transfer: assert property (p_transfer) else $error("update did not transfer");

    property p_profile;
        @(posedge core_clk) disable iff (rst) profChange |=> activeProfile == $past(profilePins);
    endproperty
    a_profile: assert property (p_profile) else $error("profile not captured");

    property p_pulse;
        @(posedge core_clk) disable iff (rst) intUpdate && intUpdEn ##1 intUpdEn |-> s_pulseHigh;
    endproperty
    a_pulse: assert property (p_pulse) else $error("strobe pulse too short");

    property p_static;
        @(posedge core_clk) disable iff (rst) intUpdEn && staticHigh |=> updatePinOut && !intUpdate;
    endproperty
    a_static: assert property (p_static) else $error("strobe not static high");

    property p_manualZero;
        @(posedge core_clk) disable iff (rst)
            keyClockRun && !autoSel && manExt && !amplitudeKeying |=> ampScale == 14'h0000;
    endproperty
    a_manualZero: assert property (p_manualZero) else $error("manual keying not zero");
endmodule
`default_nettype wire

// ===== rtl/ramp_pkg.sv
// Purpose: Shared constants for amplitude keying, profile select and update strobe control
// Assumes: Single 10 MHz core clock, registers written through a simple write port
// Notes: Buffered registers move to active copies on every update event
// What this block does
// - Keying works only in single tone mode
// - Keying disabled: ignore inputs, stop keying clocks
// - Auto-ramp select picks automatic or manual mode
// - Manual external: pin low zero, high scale
// - Ramp register: interval, maximum, step code fields
// - Auto mode: pin high up, low down
// - Step timer 16-bit at quarter core clock
// - Pin high: ramp from zero up to maximum
// - Pin low: ramp down to zero
// - Ramp output zero at reset, disabled, manual
// - Step code 00..11 gives 1,2,4,8
// - Ramp output never exceeds programmed maximum, except for one cycle after an update lowers it
// - Step timer reloads interval on each expiry
// - Reload timer on auto select rise, pin change
// - Reload-on-strobe bit restarts timer on updates
// - Three profile pins select one of eight
// - Strobe rising edge copies registers to active while internal update is off
// - Profile pin change also transfers register data
// - Internal update drives strobe pin, 12-cycle pulse
// - Rate bits divide quarter clock feeding counter
// - Repetition rate core clock over 2^A times B
// - Rate word 3 or less: pin held high
package ramp_pkg;
    localparam logic [4:0] CTRL_ADDR = 5'h01;
    localparam logic [4:0] RATE_ADDR = 5'h04;
    localparam logic [4:0] RAMP_ADDR = 5'h09;
    localparam logic [4:0] STATUS_ADDR = 5'h1f;
    // Control word two bit positions
    localparam int KEY_EN_BIT = 0;
    localparam int AUTO_SEL_BIT = 1;
    localparam int MAN_EXT_BIT = 2;
    localparam int RELOAD_BIT = 3;
    localparam int INT_UPD_BIT = 4;
    localparam int RATE_CODE_LSB = 5;
    localparam int CTRL_WIDTH = 7;
    // Ramp register fields
    localparam int INTERVAL_LSB = 16;
    localparam int MAX_LSB = 2;
    localparam int STEP_LSB = 0;
    // Reset values
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 7'h00;
    localparam logic [31:0] RAMP_RESET = 32'h0000_0000;
    localparam logic [31:0] RATE_RESET = 32'h0000_0000;
    localparam logic [13:0] FULL_SCALE = 14'h3fff;
    // Timing
    localparam int CORE_CLK_HZ = 10_000_000;
    localparam int QUARTER_DIV = 4;
    localparam logic [3:0] STROBE_PULSE_CYCLES = 4'hc;
    localparam logic [31:0] STATIC_RATE_MAX = 32'h0000_0003;
endpackage

// ===== rtl/edge_sense.sv
// Purpose: Combinational change detector for synchronous pin groups, rising-edge detector on bit 0 only
// Assumes: Inputs already synchronous to the clock
// Notes: No latency from pin to pulse; the pin is compared with its registered level from the last cycle
`timescale 1ns/1ns
`default_nettype none
module edge_sense #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Sensed level and events
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] prevLevel,
    output logic changed,
    output logic rose
);
    logic [WIDTH-1:0] prev_reg;
    logic [WIDTH-1:0] prev_next;

    always_comb begin
        prev_next = level;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= prev_next;
        end
    end

    assign prevLevel = prev_reg;
    assign changed = (level != prev_reg);
    assign rose = level[0] && !prev_reg[0];
endmodule
`default_nettype wire

// ===== verification/host_model.sv
// Purpose: Host controller model driving register port, mode, keying and profile pins
// Assumes: Requests launched by non-blocking assignment just after a rising core_clk edge
// Notes: Strobe wire resolves host drive against the device drive from its enable
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // Clock
    input wire logic core_clk,
    // Register port
    output logic regWrite,
    output logic regRead,
    output logic [4:0] regAddr,
    output logic [31:0] regWdata,
    input wire logic [31:0] regRdata,
    // Mode, keying and profile pins
    output logic singleToneMode,
    output logic amplitudeKeying,
    output logic profile_select_bit2,
    output logic profile_select_bit1,
    output logic profile_select_bit0,
    // Strobe pin
    output logic updatePinIn,
    input wire logic updatePinOut,
    input wire logic updatePinOe_n
);
    logic strobeDrv;
    // Device output wins while its enable is low
    assign updatePinIn = updatePinOe_n ? strobeDrv : updatePinOut;
    // Address and data stay unknown until the first access; the design ignores them while idle
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        amplitudeKeying = 1'b0;
        strobeDrv = 1'b0;
    end
    // Idle levels of mode and profile pins, set while reset is held
    task automatic park(input logic tone, input logic [2:0] p);
        singleToneMode <= tone;
        {profile_select_bit2, profile_select_bit1, profile_select_bit0} <= p;
    endtask
    task automatic writeReg(input logic [4:0] addr, input logic [31:0] data);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= addr;
        regWdata <= data;
        @(posedge core_clk);
        regWrite <= 1'b0;
        // Stale data must not look valid after the write
        regWdata <= ~data;
    endtask
    task automatic readReg(input logic [4:0] addr, output logic [31:0] data);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= addr;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        data = regRdata;
    endtask
    task automatic strobe;
        @(posedge core_clk);
        strobeDrv <= 1'b1;
        repeat (2) @(posedge core_clk);
        strobeDrv <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic setProfile(input logic [2:0] p);
        @(posedge core_clk);
        {profile_select_bit2, profile_select_bit1, profile_select_bit0} <= p;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic setKey(input logic v);
        @(posedge core_clk);
        amplitudeKeying <= v;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic setTone(input logic v);
        @(posedge core_clk);
        singleToneMode <= v;
        @(posedge core_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// ===== verification/amplitude_ramp_and_update_control_test.sv
// Purpose: Self-checking bench for keying ramp, profile capture and update strobe
// Assumes: Host model drives all device inputs except clock and reset
// Notes: Outputs sampled one ns after an edge or on the falling edge
`timescale 1ns/1ns
`default_nettype none
module amplitude_ramp_and_update_control_test;
    logic core_clk;
    logic rst;
    logic regWrite;
    logic regRead;
    logic [4:0] regAddr;
    logic [31:0] regWdata;
    logic [31:0] regRdata;
    logic singleToneMode;
    logic amplitudeKeying;
    logic [2:0] prof;
    logic updatePinIn;
    logic updatePinOut;
    logic updatePinOe_n;
    logic [13:0] ampScale;
    logic [13:0] rampAmp;
    logic [2:0] activeProfile;
    logic keyClockRun;
    int n_errors = 0;
    int num_checks = 0;
    logic [31:0] rd;
    int n;
    amplitude_ramp_and_update_control amplitude_ramp_and_update_control_i (
        .core_clk(core_clk), .rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .singleToneMode(singleToneMode),
        .amplitudeKeying(amplitudeKeying), .profile_select_bit2(prof[2]), .profile_select_bit1(prof[1]),
        .profile_select_bit0(prof[0]), .updatePinIn(updatePinIn), .updatePinOut(updatePinOut),
        .updatePinOe_n(updatePinOe_n), .ampScale(ampScale), .rampAmp(rampAmp),
        .activeProfile(activeProfile), .keyClockRun(keyClockRun));
    host_model host_model_i (
        .core_clk(core_clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .singleToneMode(singleToneMode),
        .amplitudeKeying(amplitudeKeying), .profile_select_bit2(prof[2]), .profile_select_bit1(prof[1]),
        .profile_select_bit0(prof[0]), .updatePinIn(updatePinIn), .updatePinOut(updatePinOut),
        .updatePinOe_n(updatePinOe_n));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Cycles from here until the next rise of the strobe output
    task automatic waitRise(output int cnt);
        logic prev;
        prev = updatePinOut;
        cnt = 0;
        while (cnt < 400) begin
            @(negedge core_clk);
            cnt++;
            if (prev !== 1'b1 && updatePinOut === 1'b1) break;
            prev = updatePinOut;
        end
    endtask
    initial begin
        #(100 * 20000);
        n_errors++;
        stop_test;
    end
    initial begin
        rst = 1'b1;
        host_model_i.park(1'b1, 3'h0);
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        check(rampAmp, 32'h0);
        check(ampScale, 32'h3fff);
        check(activeProfile, 32'h0);
        check(updatePinOe_n, 32'h1);
        check(keyClockRun, 32'h0);
        $display("Test reset done");
        host_model_i.writeReg(ramp_pkg::RAMP_ADDR, 32'h0002_48d0);
        host_model_i.writeReg(ramp_pkg::CTRL_ADDR, 32'hffff_ff85);
        host_model_i.readReg(ramp_pkg::RAMP_ADDR, rd);
        check(rd, 32'h0002_48d0);
        host_model_i.readReg(ramp_pkg::CTRL_ADDR, rd);
        check(rd, 32'h0000_0005);
        host_model_i.readReg(5'h10, rd);
        check(rd, 32'h0);
        check(keyClockRun, 32'h0);
        host_model_i.setProfile(3'h1);
        check(activeProfile, 32'h1);
        check(keyClockRun, 32'h1);
        host_model_i.setTone(1'b0);
        check(keyClockRun, 32'h0);
        host_model_i.setTone(1'b1);
        $display("Test registers done");
        host_model_i.setKey(1'b1);
        check(ampScale, 32'h1234);
        host_model_i.setKey(1'b0);
        check(ampScale, 32'h0);
        check(rampAmp, 32'h0);
        host_model_i.setKey(1'b1);
        host_model_i.writeReg(ramp_pkg::RAMP_ADDR, 32'h0000_0400);
        repeat (3) @(posedge core_clk);
        #1;
        check(ampScale, 32'h1234);
        host_model_i.strobe();
        check(ampScale, 32'h0100);
        for (int p = 0; p < 8; p++) begin
            host_model_i.setProfile(p[2:0]);
            check(activeProfile, p);
        end
        // Manual without external control: pin has no effect, maximum applies
        host_model_i.writeReg(ramp_pkg::CTRL_ADDR, 32'h0000_0001);
        host_model_i.setProfile(3'h6);
        host_model_i.setKey(1'b0);
        check(ampScale, 32'h0100);
        $display("Test manual and profiles done");
        // Reload-on-update set, so every later strobe restarts the step timer
        host_model_i.writeReg(ramp_pkg::CTRL_ADDR, 32'h0000_000b);
        for (int c = 0; c < 4; c++) begin
            host_model_i.writeReg(ramp_pkg::RAMP_ADDR, {16'h0002, 14'h0013, c[1:0]});
            host_model_i.strobe();
            host_model_i.setKey(1'b1);
            n = 0;
            while (rampAmp === 14'h0 && n < 50) begin
                @(negedge core_clk);
                n++;
            end
            check(rampAmp, 1 << c);
            repeat (7) @(negedge core_clk);
            check(rampAmp, 1 << c);
            @(negedge core_clk);
            check(rampAmp, 2 << c);
            repeat (200) @(negedge core_clk);
            check(rampAmp, 32'h13);
            check(ampScale, 32'h13);
            host_model_i.setKey(1'b0);
            repeat (200) @(negedge core_clk);
            check(rampAmp, 32'h0);
        end
        $display("Test automatic ramp done");
        host_model_i.writeReg(ramp_pkg::RATE_ADDR, 32'h0000_0010);
        host_model_i.writeReg(ramp_pkg::CTRL_ADDR, 32'h0000_0010);
        host_model_i.strobe();
        check(updatePinOe_n, 32'h0);
        for (int a = 0; a < 4; a++) begin
            host_model_i.writeReg(ramp_pkg::CTRL_ADDR, 32'h0000_0010 | (a << 5));
            waitRise(n);
            waitRise(n);
            waitRise(n);
            check(n, 16 << a);
            n = 0;
            while (updatePinOut === 1'b1 && n < 50) begin
                @(negedge core_clk);
                n++;
            end
            check(n, 12);
        end
        host_model_i.writeReg(ramp_pkg::RATE_ADDR, 32'h0000_0003);
        repeat (300) @(negedge core_clk);
        n = 0;
        repeat (40) begin
            @(negedge core_clk);
            if (updatePinOut === 1'b1) n++;
        end
        check(n, 40);
        $display("Test internal update done");
        stop_test;
    end
endmodule
`default_nettype wire
